//--- logic/sideband_accessory_defines.svh
// Register offsets, reset values and forced measurement codes of the accessory classifier
`ifndef SIDEBAND_ACCESSORY_DEFINES_SVH
`define SIDEBAND_ACCESSORY_DEFINES_SVH

// ============================================================
// Register offsets
`define ACC1_WINDOW_HIGH_ADDR   8'h31
`define ACC1_WINDOW_LOW_ADDR    8'h32
`define ACC1_CURRENT_ADDR       8'h33
`define ACC2_WINDOW_HIGH_ADDR   8'h34
`define ACC2_WINDOW_LOW_ADDR    8'h35
`define ACC2_CURRENT_ADDR       8'h36
`define ACC3_WINDOW_HIGH_ADDR   8'h37
`define ACC3_WINDOW_LOW_ADDR    8'h38
`define ACC3_CURRENT_ADDR       8'h39
`define ACC4_WINDOW_LOW_ADDR    8'h3A
`define ACC4_WINDOW_HIGH_ADDR   8'h3B
`define ACC4_CURRENT_ADDR       8'h3C

// ============================================================
// Reset values
`define ACC1_WINDOW_HIGH_RST    8'hAE
`define ACC1_WINDOW_LOW_RST     8'h99
`define ACC1_CURRENT_RST        2'h2
`define ACC2_WINDOW_HIGH_RST    8'h74
`define ACC2_WINDOW_LOW_RST     8'h66
`define ACC2_CURRENT_RST        2'h1
`define ACC3_WINDOW_HIGH_RST    8'hD9
`define ACC3_WINDOW_LOW_RST     8'hBF
`define ACC3_CURRENT_RST        2'h1
`define ACC4_WINDOW_HIGH_RST    8'h00
`define ACC4_WINDOW_LOW_RST     8'h00
`define ACC4_CURRENT_RST        2'h0

// ============================================================
// Field layout and forced final codes
`define CURRENT_FIELD_MSB       1
`define VOLTAGE_FLOOR_CODE      8'h00
`define VOLTAGE_OPEN_CODE       8'hFF
`define CURRENT_FLOOR_CODE      2'h0
`define CURRENT_GROUND_CODE     2'h3
`define READ_UNMAPPED_VALUE     8'h00

`endif

//--- logic/sideband_accessory_pkg.sv
// Types shared by the accessory classifier files
package sideband_accessory_pkg;

	// ============================================================
	// Codes
	typedef logic [7:0] voltage_code_type;
	typedef enum logic [1:0] {
		PULLUP_2UA   = 2'b00,
		PULLUP_8UA   = 2'b01,
		PULLUP_32UA  = 2'b10,
		PULLUP_128UA = 2'b11
	} current_code_type;

endpackage

//--- logic/accessory_window_match.sv
// One accessory window comparator: current code equality plus inclusive voltage window
`timescale 1ns/1ps
module accessory_window_match
	import sideband_accessory_pkg::*;
(
	input  wire voltage_code_type voltage_code,
	input  wire current_code_type current_code,
	input  wire voltage_code_type window_low,
	input  wire voltage_code_type window_high,
	input  wire current_code_type current_select,
	output logic                  match
);

	// Same 2-bit encoding on both sides, so a plain equality suffices
	// current code compare
	assign match = (current_code == current_select) &&
		(voltage_code >= window_low) &&
		(voltage_code <= window_high); // Inverted window never matches

endmodule

//--- logic/sideband_accessory_resistor_classifier.sv
// Accessory resistor classifier: threshold registers, final code shaping and per-pin match results
// ============================================================
// What this block does
// - Type 1 matches on current and window
// - Type 2 matches on current and window
// - Type 3 matches on current and window
// - Current setting encoding equals measured encoding
// - Thresholds compared unscaled against voltage code
// - Type 4 bounds separate, reset zero
// - Type 1 upper bound resets to 0xAE
// - Voltage code forced by abort/ground/open
// - Current code forced by abort/open/ground
// - Type 4 matches on current and window
`timescale 1ns/1ps
`include "sideband_accessory_defines.svh"
module sideband_accessory_resistor_classifier
	import sideband_accessory_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_write,
	input  wire logic             reg_read,
	output logic [7:0]            reg_rdata,
	input  wire logic             meas_done,
	input  wire logic             meas_pin,
	input  wire voltage_code_type meas_voltage_code,
	input  wire current_code_type meas_current_code,
	input  wire logic             meas_open,
	input  wire logic             meas_ground,
	input  wire logic             meas_abort,
	output voltage_code_type      pin1_final_voltage_code,
	output current_code_type      pin1_final_current_code,
	output voltage_code_type      pin2_final_voltage_code,
	output current_code_type      pin2_final_current_code,
	output logic [3:0]            pin1_accessory_match,
	output logic [3:0]            pin2_accessory_match,
	output logic                  result_valid,
	output logic                  result_pin
);

	// ============================================================
	// Address and reset tables, one entry per accessory type
	localparam int ACCESSORY_COUNT = 4;
	localparam logic [7:0] LOW_ADDR [ACCESSORY_COUNT] = '{`ACC1_WINDOW_LOW_ADDR, `ACC2_WINDOW_LOW_ADDR,
		`ACC3_WINDOW_LOW_ADDR, `ACC4_WINDOW_LOW_ADDR};
	localparam logic [7:0] HIGH_ADDR [ACCESSORY_COUNT] = '{`ACC1_WINDOW_HIGH_ADDR, `ACC2_WINDOW_HIGH_ADDR,
		`ACC3_WINDOW_HIGH_ADDR, `ACC4_WINDOW_HIGH_ADDR};
	localparam logic [7:0] CURRENT_ADDR [ACCESSORY_COUNT] = '{`ACC1_CURRENT_ADDR, `ACC2_CURRENT_ADDR,
		`ACC3_CURRENT_ADDR, `ACC4_CURRENT_ADDR};
	localparam logic [7:0] LOW_RST [ACCESSORY_COUNT] = '{`ACC1_WINDOW_LOW_RST, `ACC2_WINDOW_LOW_RST,
		`ACC3_WINDOW_LOW_RST, `ACC4_WINDOW_LOW_RST};
	localparam logic [7:0] HIGH_RST [ACCESSORY_COUNT] = '{`ACC1_WINDOW_HIGH_RST, `ACC2_WINDOW_HIGH_RST,
		`ACC3_WINDOW_HIGH_RST, `ACC4_WINDOW_HIGH_RST};
	localparam logic [1:0] CURRENT_RST [ACCESSORY_COUNT] = '{`ACC1_CURRENT_RST, `ACC2_CURRENT_RST,
		`ACC3_CURRENT_RST, `ACC4_CURRENT_RST};

	voltage_code_type window_low     [ACCESSORY_COUNT];
	voltage_code_type window_high    [ACCESSORY_COUNT];
	current_code_type current_select [ACCESSORY_COUNT];
	voltage_code_type next_voltage;
	current_code_type next_current;
	logic [3:0]       match_now;
	logic [7:0]       next_rdata;

	// ============================================================
	// Threshold registers and comparators
	genvar i;
	generate
		for (i = 0; i < ACCESSORY_COUNT; i++) begin : g_accessory
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					window_low[i]  <= LOW_RST[i];
					window_high[i] <= HIGH_RST[i];
				end else if (reg_write) begin
					if (reg_addr == LOW_ADDR[i]) begin
						window_low[i] <= reg_wdata;
					end
					if (reg_addr == HIGH_ADDR[i]) begin
						window_high[i] <= reg_wdata;
					end
				end
			end

			// Only the low two bits exist; upper bits are dropped on write
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					current_select[i] <= current_code_type'(CURRENT_RST[i]);
				end else if (reg_write && reg_addr == CURRENT_ADDR[i]) begin
					current_select[i] <= current_code_type'(reg_wdata[`CURRENT_FIELD_MSB:0]);
				end
			end

			accessory_window_match accessory_window_match_inst (
				.voltage_code   (next_voltage),
				.current_code   (next_current),
				.window_low     (window_low[i]),
				.window_high    (window_high[i]),
				.current_select (current_select[i]),
				.match          (match_now[i])
			);
		end
	endgenerate

	// ============================================================
	// Register read port
	// Read mux: unmapped offsets answer zero, reserved current bits read zero
	always_comb begin
		next_rdata = `READ_UNMAPPED_VALUE;
		for (int k = 0; k < ACCESSORY_COUNT; k++) begin
			if (reg_addr == LOW_ADDR[k]) begin
				next_rdata = window_low[k];
			end
			if (reg_addr == HIGH_ADDR[k]) begin
				next_rdata = window_high[k];
			end
			if (reg_addr == CURRENT_ADDR[k]) begin
				next_rdata = {6'h00, current_select[k]};
			end
		end
	end

	// Read data is held until the next read strobe
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end
	end

	// ============================================================
	// Final code shaping
	// Abort is checked first so an abort flagged with open still floors the voltage
	// forced voltage code
	always_comb begin
		next_voltage = meas_voltage_code;
		next_current = meas_current_code;
		if (meas_abort || meas_ground) begin
			next_voltage = `VOLTAGE_FLOOR_CODE;
		end else if (meas_open) begin
			next_voltage = `VOLTAGE_OPEN_CODE;
		end
		if (meas_abort || meas_open) begin
			next_current = current_code_type'(`CURRENT_FLOOR_CODE);
		end else if (meas_ground) begin
			next_current = current_code_type'(`CURRENT_GROUND_CODE);
		end
	end

	// ============================================================
	// Per-pin results
	// Thresholds are sampled at completion; later register writes do not re-grade old results
	// per-pin re-evaluation
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin1_final_voltage_code <= `VOLTAGE_FLOOR_CODE;
			pin1_final_current_code <= current_code_type'(`CURRENT_FLOOR_CODE);
			pin1_accessory_match    <= 4'h0;
			pin2_final_voltage_code <= `VOLTAGE_FLOOR_CODE;
			pin2_final_current_code <= current_code_type'(`CURRENT_FLOOR_CODE);
			pin2_accessory_match    <= 4'h0;
		end else if (meas_done && !meas_pin) begin
			pin1_final_voltage_code <= next_voltage;
			pin1_final_current_code <= next_current;
			pin1_accessory_match    <= match_now;
		end else if (meas_done && meas_pin) begin
			pin2_final_voltage_code <= next_voltage;
			pin2_final_current_code <= next_current;
			pin2_accessory_match    <= match_now;
		end
	end

	// Completion pulse tells the reader which pin just refreshed
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			result_valid <= 1'b0;
			result_pin   <= 1'b0;
		end else begin
			result_valid <= meas_done;
			if (meas_done) begin
				result_pin <= meas_pin;
			end
		end
	end

	// ============================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence clean_pin1_s;
		meas_done && !meas_pin && !meas_abort && !meas_open && !meas_ground;
	endsequence

	sequence clean_pin2_s;
		meas_done && meas_pin && !meas_abort && !meas_open && !meas_ground;
	endsequence

	type1_match_a: assert property (clean_pin1_s and
		(meas_current_code == current_select[0] && meas_voltage_code >= window_low[0] &&
		meas_voltage_code <= window_high[0]) |=> pin1_accessory_match[0] && result_valid)
		else $error("type 1 match missed");
	type1_reject_a: assert property (clean_pin1_s and
		(meas_current_code != current_select[0]) |=> !pin1_accessory_match[0])
		else $error("type 1 matched on wrong current");
	type2_match_a: assert property (clean_pin2_s and
		(meas_current_code == current_select[1] && meas_voltage_code >= window_low[1] &&
		meas_voltage_code <= window_high[1]) |=> pin2_accessory_match[1])
		else $error("type 2 match missed");
	type3_edge_a: assert property (clean_pin1_s and
		(meas_voltage_code == window_low[2] && window_low[2] <= window_high[2] &&
		meas_current_code == current_select[2]) |=> pin1_accessory_match[2])
		else $error("type 3 lower bound not inclusive");
	type3_above_a: assert property (clean_pin2_s and
		(meas_voltage_code > window_high[2]) |=> !pin2_accessory_match[2])
		else $error("type 3 matched above window");
	type4_match_a: assert property (clean_pin2_s and
		(meas_current_code == current_select[3] && meas_voltage_code >= window_low[3] &&
		meas_voltage_code <= window_high[3]) |=> pin2_accessory_match[3])
		else $error("type 4 match missed");
	open_code_a: assert property (meas_done && !meas_pin && meas_open && !meas_abort && !meas_ground |=>
		pin1_final_voltage_code == 8'hFF && pin1_final_current_code == 2'h0)
		else $error("open result not forced");
	// Open beats ground for the current code, so only a pure ground result is checked here
	ground_code_a: assert property (meas_done && meas_pin && meas_ground && !meas_abort && !meas_open |=>
		pin2_final_voltage_code == 8'h00 && pin2_final_current_code == 2'h3)
		else $error("ground result not forced");
	pin_hold_a: assert property (meas_done && meas_pin |=> result_pin &&
		$stable(pin1_accessory_match) && $stable(pin1_final_voltage_code))
		else $error("pin 1 result disturbed by pin 2");
	reset_value_a: assert property (disable iff (1'b0) rst |=> window_high[0] == 8'hAE &&
		window_low[3] == 8'h00 && window_high[3] == 8'h00) else $error("threshold reset wrong");
	type4_split_a: assert property (reg_write && reg_addr == 8'h3A |=>
		window_low[3] == $past(reg_wdata) && $stable(window_high[3])) else $error("type 4 bounds not separate");

endmodule

//--- testbench/measurement_engine_model.sv
// Measurement engine model that hands final sideband results to the classifier
`timescale 1ns/1ps
module measurement_engine_model
	import sideband_accessory_pkg::*;
(
	input  wire logic        clk_sys,
	output logic             meas_done,
	output logic             meas_pin,
	output voltage_code_type meas_voltage_code,
	output current_code_type meas_current_code,
	output logic             meas_open,
	output logic             meas_ground,
	output logic             meas_abort
);
	// ============================================================
	// Idle levels
	initial begin
		{meas_done, meas_pin, meas_open, meas_ground, meas_abort} = 5'h00;
		meas_voltage_code = 8'h00;
		meas_current_code = PULLUP_2UA;
	end

	// One result; kind 0 clean, 1 open, 2 ground, 3 abort
	task automatic send(input logic pin, input logic [7:0] v, input logic [1:0] i, input logic [1:0] kind);
		@(negedge clk_sys);
		meas_done = 1'h1;
		meas_pin = pin;
		meas_voltage_code = v;
		meas_current_code = current_code_type'(i);
		{meas_open, meas_ground, meas_abort} = {kind == 2'h1, kind == 2'h2, kind == 2'h3};
		@(negedge clk_sys);
		meas_done = 1'h0;
		// Qualifiers are stale after the pulse, so show changed values rather than the last ones
		meas_pin = ~pin;
		meas_voltage_code = ~v;
		meas_current_code = current_code_type'(~i);
		{meas_open, meas_ground, meas_abort} = ~{meas_open, meas_ground, meas_abort};
	endtask
endmodule

//--- testbench/sideband_accessory_resistor_classifier_tb.sv
// Self-checking bench for the accessory resistor classifier
`timescale 1ns/1ps
module sideband_accessory_resistor_classifier_tb
	import sideband_accessory_pkg::*;
;
	logic             clk_sys;
	logic             rst;
	logic             reg_write;
	logic             reg_read;
	logic [7:0]       reg_addr;
	logic [7:0]       reg_wdata;
	logic [7:0]       reg_rdata;
	logic             meas_done;
	logic             meas_pin;
	logic             meas_open;
	logic             meas_ground;
	logic             meas_abort;
	voltage_code_type meas_voltage_code;
	voltage_code_type p1v;
	voltage_code_type p2v;
	current_code_type meas_current_code;
	current_code_type p1i;
	current_code_type p2i;
	logic [3:0]       p1m;
	logic [3:0]       p2m;
	logic             result_valid;
	logic             result_pin;
	int               n_fail;
	int               compares;
	int               i;
	logic [7:0]       rst_tab [12] = '{8'hAE, 8'h99, 8'h02, 8'h74, 8'h66, 8'h01,
		8'hD9, 8'hBF, 8'h01, 8'h00, 8'h00, 8'h00};

	// ============================================================
	// Clock, design and engine
	initial begin
		clk_sys = 1'h0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	sideband_accessory_resistor_classifier sideband_accessory_resistor_classifier_inst (
		.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.meas_done(meas_done), .meas_pin(meas_pin), .meas_voltage_code(meas_voltage_code),
		.meas_current_code(meas_current_code), .meas_open(meas_open), .meas_ground(meas_ground),
		.meas_abort(meas_abort), .pin1_final_voltage_code(p1v), .pin1_final_current_code(p1i),
		.pin2_final_voltage_code(p2v), .pin2_final_current_code(p2i), .pin1_accessory_match(p1m),
		.pin2_accessory_match(p2m), .result_valid(result_valid), .result_pin(result_pin));

	measurement_engine_model measurement_engine_model_inst (
		.clk_sys(clk_sys), .meas_done(meas_done), .meas_pin(meas_pin),
		.meas_voltage_code(meas_voltage_code), .meas_current_code(meas_current_code),
		.meas_open(meas_open), .meas_ground(meas_ground), .meas_abort(meas_abort));

	// ============================================================
	// Tasks
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected=%h seen=%h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		{reg_addr, reg_wdata, reg_write} = {a, d, 1'h1};
		@(negedge clk_sys);
		reg_write = 1'h0;
	endtask

	// Read data is registered, so it is looked at one cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		{reg_addr, reg_read} = {a, 1'h1};
		@(negedge clk_sys);
		reg_read = 1'h0;
		chk("reg_rdata", reg_rdata, e);
	endtask

	task automatic meas(input logic p, input logic [7:0] v, input logic [1:0] c, input logic [1:0] k,
		input logic [7:0] ev, input logic [1:0] ec, input logic [3:0] em);
		measurement_engine_model_inst.send(p, v, c, k);
		chk("result_valid", {7'h00, result_valid}, 8'h01);
		chk("result_pin", {7'h00, result_pin}, {7'h00, p});
		chk("final_voltage", p ? p2v : p1v, ev);
		chk("final_current", {6'h00, p ? p2i : p1i}, {6'h00, ec});
		chk("match", {4'h0, p ? p2m : p1m}, {4'h0, em});
	endtask

	task final_report;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog well beyond the roughly 150 cycles the tests need
	initial begin
		#125000;
		n_fail++;
		final_report;
	end

	// ============================================================
	// Tests
	initial begin
		{rst, reg_write, reg_read} = 3'h4;
		{reg_addr, reg_wdata} = 16'h0000;
		n_fail = 0;
		compares = 0;
		repeat (5) @(negedge clk_sys);
		rst = 1'h0;
		for (i = 0; i < 12; i++) rd_chk(8'h31 + i[7:0], rst_tab[i]);
		rd_chk(8'h40, 8'h00);
		for (i = 0; i < 12; i++) wr(8'h31 + i[7:0], 8'hFF);
		wr(8'h40, 8'h5A);
		// Current selects keep only their two low bits
		for (i = 0; i < 12; i++) rd_chk(8'h31 + i[7:0], (i % 3 == 2) ? 8'h03 : 8'hFF);
		rd_chk(8'h40, 8'h00);
		// Second reset in mid-run restores the thresholds
		rst = 1'h1;
		repeat (5) @(negedge clk_sys);
		rst = 1'h0;
		rd_chk(8'h31, 8'hAE);
		rd_chk(8'h3B, 8'h00);
		meas(1'h0, 8'h98, 2'h2, 2'h0, 8'h98, 2'h2, 4'h0);
		meas(1'h0, 8'hAF, 2'h2, 2'h0, 8'hAF, 2'h2, 4'h0);
		meas(1'h0, 8'hA0, 2'h1, 2'h0, 8'hA0, 2'h1, 4'h0);
		meas(1'h0, 8'hBF, 2'h1, 2'h0, 8'hBF, 2'h1, 4'h4);
		meas(1'h0, 8'h99, 2'h2, 2'h0, 8'h99, 2'h2, 4'h1);
		meas(1'h0, 8'hAE, 2'h2, 2'h0, 8'hAE, 2'h2, 4'h1);
		meas(1'h1, 8'h66, 2'h1, 2'h0, 8'h66, 2'h1, 4'h2);
		meas(1'h1, 8'h74, 2'h1, 2'h0, 8'h74, 2'h1, 4'h2);
		meas(1'h1, 8'h75, 2'h1, 2'h0, 8'h75, 2'h1, 4'h0);
		meas(1'h1, 8'hD9, 2'h1, 2'h0, 8'hD9, 2'h1, 4'h4);
		meas(1'h1, 8'hDA, 2'h1, 2'h0, 8'hDA, 2'h1, 4'h0);
		meas(1'h1, 8'hBF, 2'h0, 2'h0, 8'hBF, 2'h0, 4'h0);
		// Pin one last matched type 1, so a leak of pin two results would show here
		chk("pin1_hold_match", {4'h0, p1m}, 8'h01);
		chk("pin1_hold_voltage", p1v, 8'hAE);
		meas(1'h0, 8'h55, 2'h3, 2'h3, 8'h00, 2'h0, 4'h8);
		meas(1'h1, 8'h55, 2'h0, 2'h2, 8'h00, 2'h3, 4'h0);
		meas(1'h0, 8'h55, 2'h3, 2'h1, 8'hFF, 2'h0, 4'h0);
		wr(8'h3A, 8'h10);
		wr(8'h3B, 8'h20);
		wr(8'h3C, 8'h03);
		meas(1'h1, 8'h10, 2'h3, 2'h0, 8'h10, 2'h3, 4'h8);
		meas(1'h1, 8'h21, 2'h3, 2'h0, 8'h21, 2'h3, 4'h0);
		@(negedge clk_sys);
		chk("valid_low", {7'h00, result_valid}, 8'h00);
		// Every current code selected once against the same window
		for (i = 0; i < 4; i++) begin
			wr(8'h33, i[7:0]);
			meas(1'h0, 8'hA0, i[1:0], 2'h0, 8'hA0, i[1:0], 4'h1);
		end
		final_report;
	end
endmodule
